// ==== pkg/dpram_pkg.sv ====
// shared widths, reset values and encodings of the dual-port ram port
package dpram_pkg;

   // ------------------------------------------------------------
   // array shape
   // ------------------------------------------------------------
   localparam int          DATA_W       = 8;
   localparam int          ADDR_W       = 16;
   localparam int          DEPTH        = 65536;
   localparam int          TOP_ADDR_BIT = 15;

   // ------------------------------------------------------------
   // two-entry buffer
   // ------------------------------------------------------------
   localparam int          BUF_DEPTH    = 2;
   localparam int          BUF_PTR_W    = 1;
   localparam int          BUF_CNT_W    = 2;

   // ------------------------------------------------------------
   // values after reset and fixed values
   // ------------------------------------------------------------
   localparam logic [ADDR_W-1:0]    ADDR_RESET  = 16'h0000;
   localparam logic [ADDR_W-1:0]    ADDR_CLEAR  = 16'h0000;
   localparam logic [ADDR_W-1:0]    ADDR_STEP   = 16'h0001;
   localparam logic [DATA_W-1:0]    DATA_RESET  = 8'h00;
   localparam logic [BUF_CNT_W-1:0] COUNT_RESET = 2'h0;
   localparam logic [BUF_CNT_W-1:0] COUNT_FULL  = 2'h2;

   // output stage encoding of output_stage_select
   localparam logic        STAGE_FLOW   = 1'b0;
   localparam logic        STAGE_PIPE   = 1'b1;

   // address source chosen at each edge
   typedef enum logic [1:0] {
      SRC_CLEAR,
      SRC_EXTERNAL,
      SRC_STEP,
      SRC_HOLD
   } addr_src_t;

endpackage

// ==== design/addr_counter.sv ====
// loadable address counter with clear, step and hold
`timescale 1ns/1ps
module addr_counter
   import dpram_pkg::*;
(
   input  wire logic              clock,
   input  wire logic              nrst,
   input  wire logic              address_load_strobe,
   input  wire logic              counter_step_enable,
   input  wire logic              counter_clear,
   input  wire logic              deep_variant,
   input  wire logic [ADDR_W-1:0] port_address,
   output logic      [ADDR_W-1:0] address_used
);

   logic [ADDR_W-1:0] count;
   logic [ADDR_W-1:0] next_count;
   addr_src_t         source;

   // ------------------------------------------------------------
   // source priority: clear, load, step, hold
   // ------------------------------------------------------------
   assign source = !counter_clear       ? SRC_CLEAR    :  // [RULE8]
                   !address_load_strobe ? SRC_EXTERNAL :  // [RULE5]
                   !counter_step_enable ? SRC_STEP     :  // [RULE6]
                                          SRC_HOLD;       // [RULE7]

   always_comb begin
      unique case (source)
         SRC_CLEAR:    next_count = ADDR_CLEAR;
         SRC_EXTERNAL: next_count = port_address;
         // plain wrap from top word to zero
         SRC_STEP:     next_count = count + ADDR_STEP;  // [RULE17]
         SRC_HOLD:     next_count = count;
      endcase
      // small variant has no top address line
      if (!deep_variant) begin
         next_count[TOP_ADDR_BIT] = 1'b0;  // [RULE13]
      end
   end

   // the address chosen at this edge is also used by this access
   assign address_used = next_count;

   // counter runs whatever the selects are
   always_ff @(posedge clock) begin  // [RULE9]
      if (!nrst) begin
         count <= ADDR_RESET;
      end else begin
         count <= next_count;
      end
   end

endmodule

// ==== design/two_entry_buffer.sv ====
// two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module two_entry_buffer
   import dpram_pkg::*;
#(
   parameter int WIDTH = DATA_W
)
(
   input  wire logic             clock,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   logic [WIDTH-1:0]     slot [BUF_DEPTH];
   logic [BUF_PTR_W-1:0] wr_ptr;
   logic [BUF_PTR_W-1:0] rd_ptr;
   logic [BUF_CNT_W-1:0] count;
   wire                  push = in_valid && in_ready;
   wire                  pop  = out_valid && out_ready;

   assign in_ready  = (count != COUNT_FULL);
   assign out_valid = (count != COUNT_RESET);
   assign out_data  = slot[rd_ptr];

   always_ff @(posedge clock) begin
      if (push) begin
         slot[wr_ptr] <= in_data;
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
         count  <= COUNT_RESET;
      end else begin
         wr_ptr <= wr_ptr + BUF_PTR_W'(push);
         rd_ptr <= rd_ptr + BUF_PTR_W'(pop);
         count  <= count + BUF_CNT_W'(push) - BUF_CNT_W'(pop);
      end
   end

endmodule

// ==== design/dpram_port.sv ====
// synchronous dual-port ram: full pin port plus a second access port
//
// What this block does
// [RULE1] a deselect seen at an edge floats the data pins and idles the port.
// [RULE2] selected with direction low, the data bus is written to the word.
// [RULE3] selected, direction high and output enable low drives the word out.
// [RULE4] output enable high floats the data pins at once, without the clock.
// [RULE5] strobe low with clear inactive loads the external address for use.
// [RULE6] strobe high and step enable low advance the counter by one.
// [RULE7] strobe and step enable both high reuse the held counter value.
// [RULE8] clear low forces the address to zero above strobe and step.
// [RULE9] load, clear and step all work while the port is deselected.
// [RULE10] pipelined read data comes one cycle after flow-through data.
// [RULE11] in flow-through mode the selects pass one register stage.
// [RULE12] in pipelined mode the selects pass two register stages.
// [RULE13] words are 8 bits, 64K deep, or 32K with the top bit unused.
// [RULE14] both ports reach any word of the shared array in the same cycle.
// [RULE15] the controller keeps the output stage select static.
// [RULE16] the controller presents all synchronous inputs on the clock edge.
// [RULE17] the counter spans the full address and wraps to zero.
`timescale 1ns/1ps
module dpram_port
   import dpram_pkg::*;
#(
   parameter bit DEEP = 1'b1
)
(
   input  wire logic              clock,
   input  wire logic              nrst,
   // pin port
   input  wire logic              select_low_active,
   input  wire logic              select_high_active,
   input  wire logic              read_not_write,
   input  wire logic              output_enable_n,
   input  wire logic [ADDR_W-1:0] port_address,
   input  wire logic              address_load_strobe,
   input  wire logic              counter_step_enable,
   input  wire logic              counter_clear,
   input  wire logic              output_stage_select,
   input  wire logic [DATA_W-1:0] port_data_bus_in,
   output logic      [DATA_W-1:0] port_data_bus_out,
   output logic                   port_data_bus_oe_n,
   output logic                   standby,
   // second access port
   input  wire logic              aux_req_valid,
   output logic                   aux_req_ready,
   input  wire logic              aux_write,
   input  wire logic [ADDR_W-1:0] aux_address,
   input  wire logic [DATA_W-1:0] aux_wdata,
   output logic                   aux_rd_valid,
   input  wire logic              aux_rd_ready,
   output logic      [DATA_W-1:0] aux_rdata
);

   // ------------------------------------------------------------
   // shared array
   // ------------------------------------------------------------
   logic [DATA_W-1:0] mem [DEPTH];

   // ------------------------------------------------------------
   // decode at the edge
   // ------------------------------------------------------------
   logic [ADDR_W-1:0] address_used;
   logic [ADDR_W-1:0] aux_addr_used;
   wire               selected;
   wire               pin_write;
   wire               pin_read;
   wire               aux_take;
   wire               aux_wr;
   wire               aux_rd;
   wire               pend_move;
   wire               deep_variant = DEEP;

   function automatic logic chip_selected(input logic low_sel,
                                          input logic high_sel);
      chip_selected = !low_sel && high_sel;
   endfunction

   assign selected  = chip_selected(select_low_active,
                                    select_high_active);  // [RULE1]
   assign pin_write = selected && !read_not_write;       // [RULE2]
   assign pin_read  = selected && read_not_write;        // [RULE3]

   addr_counter u_counter (
      .clock               (clock),
      .nrst                (nrst),
      .address_load_strobe (address_load_strobe),
      .counter_step_enable (counter_step_enable),
      .counter_clear       (counter_clear),
      .deep_variant        (deep_variant),
      .port_address        (port_address),
      .address_used        (address_used)
   );

   // second port sees the same array shape
   always_comb begin
      aux_addr_used = aux_address;
      if (!deep_variant) begin
         aux_addr_used[TOP_ADDR_BIT] = 1'b0;  // [RULE13]
      end
   end

   // ------------------------------------------------------------
   // pin port read path
   // ------------------------------------------------------------
   logic [DATA_W-1:0] flow_data;
   logic [DATA_W-1:0] pipe_data;
   logic              sel_stage1;
   logic              sel_stage2;
   logic              read_stage1;
   logic              read_stage2;
   wire               pipe_mode;
   wire               stage_drive;
   wire               drive;

   // read stops updating while idle, which is the standby saving
   always_ff @(posedge clock) begin
      if (pin_read) begin
         flow_data <= mem[address_used];  // [RULE3]
      end
   end

   always_ff @(posedge clock) begin
      pipe_data <= flow_data;  // [RULE10]
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         sel_stage1  <= 1'b0;
         sel_stage2  <= 1'b0;
         read_stage1 <= 1'b0;
         read_stage2 <= 1'b0;
      end else begin
         sel_stage1  <= selected;      // [RULE11]
         sel_stage2  <= sel_stage1;    // [RULE12]
         read_stage1 <= pin_read;
         read_stage2 <= read_stage1;
      end
   end

   // stage select is treated as static, so no sampling is done
   assign pipe_mode   = (output_stage_select == STAGE_PIPE);  // [RULE15]
   assign stage_drive = pipe_mode ? (sel_stage2 && read_stage2)
                                  : (sel_stage1 && read_stage1);  // [RULE1]
   // output enable bypasses every register
   assign drive       = stage_drive && !output_enable_n;  // [RULE4]

   assign port_data_bus_out  = pipe_mode ? pipe_data : flow_data;  // [RULE10]
   assign port_data_bus_oe_n = !drive;
   assign standby            = !sel_stage1;  // [RULE1]

   // ------------------------------------------------------------
   // second port
   // ------------------------------------------------------------
   logic              pend_valid;
   logic [DATA_W-1:0] pend_data;
   logic              buf_in_ready;

   // a read may only start when its result has somewhere to go
   assign aux_req_ready = !pend_valid || buf_in_ready;
   assign aux_take      = aux_req_valid && aux_req_ready;
   assign aux_wr        = aux_take && aux_write;
   assign aux_rd        = aux_take && !aux_write;
   assign pend_move     = !pend_valid || buf_in_ready;

   always_ff @(posedge clock) begin
      if (aux_rd) begin
         pend_data <= mem[aux_addr_used];  // [RULE14]
      end
   end

   always_ff @(posedge clock) begin
      if (!nrst) begin
         pend_valid <= 1'b0;
      end else if (pend_move) begin
         pend_valid <= aux_rd;
      end
   end

   two_entry_buffer #(
      .WIDTH (DATA_W)
   ) u_buffer (
      .clock     (clock),
      .nrst      (nrst),
      .in_valid  (pend_valid),
      .in_ready  (buf_in_ready),
      .in_data   (pend_data),
      .out_valid (aux_rd_valid),
      .out_ready (aux_rd_ready),
      .out_data  (aux_rdata)
   );

   // ------------------------------------------------------------
   // array writes
   // ------------------------------------------------------------
   // same word written by both ports in one cycle: pin port wins
   always_ff @(posedge clock) begin
      if (aux_wr) begin
         mem[aux_addr_used] <= aux_wdata;  // [RULE14]
      end
      if (pin_write) begin
         mem[address_used] <= port_data_bus_in;  // [RULE2]
      end
   end

endmodule

// ==== sim/dpram_port_props.sv ====
// concurrent checks on the pins of the dual-port ram port
`timescale 1ns/1ps
module dpram_port_props
   import dpram_pkg::*;
#(
   parameter bit DEEP = 1'b1
)
(
   input wire logic              clock,
   input wire logic              nrst,
   input wire logic              select_low_active,
   input wire logic              select_high_active,
   input wire logic              read_not_write,
   input wire logic              output_enable_n,
   input wire logic              output_stage_select,
   input wire logic              port_data_bus_oe_n,
   input wire logic              standby,
   input wire logic              aux_req_valid,
   input wire logic              aux_req_ready,
   input wire logic              aux_write,
   input wire logic              aux_rd_valid,
   input wire logic              aux_rd_ready,
   input wire logic [DATA_W-1:0] aux_rdata
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!nrst);
   wire sel_on = !select_low_active && select_high_active;
   wire pipe   = output_stage_select;
   sequence desel;   !sel_on; endsequence
   sequence flow_rd; sel_on && read_not_write && !pipe; endsequence
   sequence pipe_rd; sel_on && read_not_write && pipe; endsequence

   chk_flow_deselect_float: assert property (
      !sel_on && !pipe |=> port_data_bus_oe_n && standby)
      else $error("port still live after deselect");
   chk_select_wakes: assert property (
      sel_on |=> !standby) else $error("standby while selected");
   chk_oe_async_off: assert property (
      output_enable_n |-> port_data_bus_oe_n) else $error("driven, oe high");
   chk_flow_read_drive: assert property (
      flow_rd ##1 !output_enable_n |-> !port_data_bus_oe_n)
      else $error("flow read not driven");
   chk_write_no_drive: assert property (
      sel_on && !read_not_write && !pipe |=> port_data_bus_oe_n)
      else $error("pins driven on write");
   chk_pipe_read_late: assert property (
      desel ##1 pipe_rd |=> port_data_bus_oe_n ##1
      (output_enable_n || !port_data_bus_oe_n))
      else $error("pipelined read timing wrong");
   chk_pipe_two_stage: assert property (
      pipe_rd ##1 desel ##1 !output_enable_n |->
      !port_data_bus_oe_n ##1 port_data_bus_oe_n)
      else $error("pipelined deselect timing wrong");
   chk_rd_word_holds: assert property (
      aux_rd_valid && !aux_rd_ready |=> aux_rd_valid && $stable(aux_rdata))
      else $error("stalled read word lost");
   chk_aux_read_answer: assert property (
      aux_req_valid && aux_req_ready && !aux_write && !aux_rd_valid
      |-> ##[1:4] aux_rd_valid) else $error("second port read unanswered");
endmodule

bind dpram_port dpram_port_props #(.DEEP(DEEP)) i_props (
   .clock(clock), .nrst(nrst), .select_low_active(select_low_active),
   .select_high_active(select_high_active),
   .read_not_write(read_not_write), .output_enable_n(output_enable_n),
   .output_stage_select(output_stage_select),
   .port_data_bus_oe_n(port_data_bus_oe_n), .standby(standby),
   .aux_req_valid(aux_req_valid), .aux_req_ready(aux_req_ready),
   .aux_write(aux_write), .aux_rd_valid(aux_rd_valid),
   .aux_rd_ready(aux_rd_ready), .aux_rdata(aux_rdata));

// ==== sim/aux_sink.sv ====
// far-side consumer of second port read words
`timescale 1ns/1ps
module aux_sink
(
   input  wire logic clock,
   input  wire logic nrst,
   input  wire logic hold_off,
   output logic      aux_rd_ready
);
   // alternating take and stall shows prompt and slow answers alike
   always_ff @(posedge clock) begin
      if (!nrst || hold_off)
         aux_rd_ready <= 1'b0;
      else
         aux_rd_ready <= !aux_rd_ready;
   end
endmodule

// ==== sim/dpram_port_tb_top.sv ====
// self-checking bench for the dual-port ram port
`timescale 1ns/1ps
module dpram_port_tb_top;
   import dpram_pkg::*;
   logic              clock, nrst, rnw, oe_in_n, ld_n, step_n, clr_n;
   logic              stage, oe_n, stby, aux_val, aux_rdy, aux_wr;
   logic              rd_val, rd_rdy, hold_off;
   logic [1:0]        sel;
   logic [ADDR_W-1:0] addr, aux_addr;
   logic [DATA_W-1:0] din, aux_wd, rd_out, aux_rd, got_q[$];
   int                mismatches, num_checks;
   logic [DATA_W-1:0] want [4] = '{8'h77, 8'h5A, 8'h11, 8'hA5};

   dpram_port #(.DEEP(1'b1)) i_dut (.clock(clock), .nrst(nrst),
      .select_low_active(sel[1]), .select_high_active(sel[0]),
      .read_not_write(rnw), .output_enable_n(oe_in_n),
      .port_address(addr), .address_load_strobe(ld_n),
      .counter_step_enable(step_n), .counter_clear(clr_n),
      .output_stage_select(stage), .port_data_bus_in(din),
      .port_data_bus_out(rd_out), .port_data_bus_oe_n(oe_n),
      .standby(stby), .aux_req_valid(aux_val), .aux_req_ready(aux_rdy),
      .aux_write(aux_wr), .aux_address(aux_addr), .aux_wdata(aux_wd),
      .aux_rd_valid(rd_val), .aux_rd_ready(rd_rdy), .aux_rdata(aux_rd));
   aux_sink i_sink (.clock(clock), .nrst(nrst), .hold_off(hold_off),
      .aux_rd_ready(rd_rdy));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (nrst && rd_val && rd_rdy) got_q.push_back(aux_rd);
   end

   // ------------------------------------------------------------
   // access and compare tasks
   // ------------------------------------------------------------
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic cmp_word(input logic [DATA_W-1:0] g, e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: word %h not %h", $time, g, e);
      end
   endtask
   task automatic cmp_bit(input logic g, e);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("unexpected at %0t: flag %b not %b", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [DATA_W-1:0] e);
      cmp_word(rd_out, e);
      cmp_bit(oe_n, 1'b0);
   endtask
   // s is {select_low_active, select_high_active}; levels are raw pins
   task automatic pin(input logic [1:0] s, input logic w, l, t, c,
                      input logic [15:0] a, input logic [7:0] d);
      @(negedge clock);
      {sel, rnw, ld_n, step_n, clr_n, addr, din} = {s, w, l, t, c, a, d};
   endtask
   task automatic do_reset(input logic m);
      @(negedge clock);
      {nrst, stage} = {1'b0, m};
      repeat (16) @(negedge clock);
      cmp_bit(oe_n, 1'b1);
      cmp_bit(stby, 1'b1);
      cmp_bit(rd_val, 1'b0);
      cmp_bit(aux_rdy, 1'b1);
      nrst = 1'b1;
   endtask
   task automatic aux_req(input logic w, input logic [15:0] a,
                          input logic [7:0] d);
      int n;
      @(negedge clock);
      {aux_val, aux_wr, aux_addr, aux_wd} = {1'b1, w, a, d};
      for (n = 0; n < 50 && aux_rdy !== 1'b1; n++) @(negedge clock);
      cmp_bit(aux_rdy, 1'b1);
      @(posedge clock);
   endtask

   initial begin
      {nrst, sel, rnw, oe_in_n, ld_n, step_n, clr_n} = 8'h30 | 8'h0F;
      {stage, addr, din, aux_val, aux_wr, aux_addr, aux_wd} = '0;
      hold_off = 1'b1;
      mismatches = 0;
      num_checks = 0;
      oe_in_n = 1'b0;
      do_reset(STAGE_FLOW);
      pin(2'b01, 0, 0, 1, 1, 16'h1234, 8'h5A);
      pin(2'b01, 0, 1, 0, 1, 16'h0000, 8'hA5);
      pin(2'b01, 0, 0, 1, 0, 16'h1234, 8'h3C);
      pin(2'b01, 0, 0, 1, 1, 16'hFFFF, 8'h11);
      pin(2'b01, 0, 1, 0, 1, 16'h0000, 8'h22);
      pin(2'b01, 1, 0, 1, 1, 16'h1234, 8'h00);
      pin(2'b01, 1, 1, 0, 1, 16'h0000, 8'h00);
      rchk(8'h5A);
      pin(2'b01, 1, 1, 1, 1, 16'h0000, 8'h00);
      rchk(8'hA5);
      pin(2'b01, 1, 0, 1, 1, 16'h0000, 8'h00);
      rchk(8'hA5);
      pin(2'b11, 1, 0, 1, 1, 16'h1234, 8'h00);
      rchk(8'h22);
      pin(2'b00, 1, 1, 0, 1, 16'h0000, 8'h00);
      cmp_bit(oe_n, 1'b1);
      cmp_bit(stby, 1'b1);
      pin(2'b01, 1, 1, 1, 1, 16'h0000, 8'h00);
      cmp_bit(oe_n, 1'b1);
      pin(2'b11, 1, 1, 1, 1, 16'h0000, 8'h00);
      rchk(8'hA5);
      // held across an edge so the checker sees it too
      oe_in_n = 1'b1;
      #1 cmp_bit(oe_n, 1'b1);
      @(negedge clock) oe_in_n = 1'b0;
      do_reset(STAGE_PIPE);
      pin(2'b01, 1, 0, 1, 1, 16'h1234, 8'h00);
      pin(2'b00, 1, 1, 1, 1, 16'h0000, 8'h00);
      cmp_bit(oe_n, 1'b1);
      pin(2'b00, 1, 1, 1, 1, 16'h0000, 8'h00);
      rchk(8'h5A);
      pin(2'b00, 1, 1, 1, 1, 16'h0000, 8'h00);
      cmp_bit(oe_n, 1'b1);
      aux_req(1, 16'h0100, 8'h77);
      aux_req(0, 16'h0100, 8'h00);
      aux_req(0, 16'h1234, 8'h00);
      aux_req(0, 16'hFFFF, 8'h00);
      @(negedge clock) aux_val = 1'b0;
      repeat (4) @(negedge clock);
      cmp_bit(aux_rdy, 1'b0);
      cmp_bit(rd_val, 1'b1);
      hold_off = 1'b0;
      aux_req(0, 16'h1235, 8'h00);
      @(negedge clock) aux_val = 1'b0;
      pin(2'b01, 1, 0, 1, 1, 16'h0100, 8'h00);
      pin(2'b00, 1, 1, 1, 1, 16'h0000, 8'h00);
      pin(2'b00, 1, 1, 1, 1, 16'h0000, 8'h00);
      rchk(8'h77);
      repeat (12) @(negedge clock);
      cmp_bit(got_q.size() == 4, 1'b1);
      foreach (got_q[i]) cmp_word(got_q[i], want[i]);
      close_out();
   end

   initial begin
      #5000;
      mismatches++;
      close_out();
   end
endmodule
